// [core/sfd_diag.sv]
module sfd_diag import sfd_pkg::*; #(
	parameter int FILT_CYCLES    = FILT_CYC,
	parameter int FO_UNIT_CYCLES = FO_UNIT_CYC
)(
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	// serial link pins
	input  wire logic              sclk,
	input  wire logic              cs_n,
	input  wire logic              si,
	input  wire logic              clock_polarity_select,
	output logic                   so,
	output logic                   so_oe,
	// raw fault detectors, asynchronous to ref_clk
	input  wire logic [NCH-1:0]    ovl_det,
	input  wire logic [NCH-1:0]    ch_ot_det,
	input  wire logic [NCH-1:0]    open_load_det,
	input  wire logic [NCH-1:0]    bypass_det,
	input  wire logic              chip_ot_det,
	input  wire logic [NREG-1:0]   cur_reached,
	// channel state and configuration, ref_clk domain
	input  wire logic [NCH-1:0]    ch_on,
	input  wire logic [NREG-1:0]   reg_mode_on,
	input  wire logic [2*NREG-1:0] fixed_off_time,
	input  wire logic              ot_flag_mode,
	// status and received command
	output logic                   fault_n,
	output logic                   ch6_diag_or_overtemp_out,
	output logic [DW-1:0]          cmd_word,
	output logic                   cmd_strobe
);
	localparam int SW = 4 * NCH + NREG + 2;

	sfd_if lnk ();

	// link logic on the host's serial clock
	sfd_spi u_spi (
		.sclk                  (sclk),
		.nrst                  (nrst),
		.clock_polarity_select (clock_polarity_select),
		.si                    (si),
		.lnk                   (lnk.link),
		.so                    (so)
	);

	// two-stage synchroniser for chip select and every fault detector input; only stage two is read
	// reset to the idle levels: select high, detectors low, so no false fault or edge follows reset
	localparam logic [SW-1:0] SYNC_IDLE = {1'b1, {(SW-1){1'b0}}};
	logic [SW-1:0] s1_ff, s2_ff;

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_ff <= SYNC_IDLE;
			s2_ff <= SYNC_IDLE;
		end
		else
		begin
			s1_ff <= {cs_n, chip_ot_det, cur_reached, bypass_det, open_load_det, ch_ot_det, ovl_det};
			s2_ff <= s1_ff;
		end
	end

	logic [NCH-1:0]  ovl_s, ot_s, open_s, byp_s;
	logic [NREG-1:0] cur_s;
	logic            chip_ot_s, cs_s;

	assign {cs_s, chip_ot_s, cur_s, byp_s, open_s, ot_s, ovl_s} = s2_ff;

	// per-channel candidate code, current limit and overtemp outrank bypass and open load
	logic [1:0] cand [NCH];
	logic [1:0] hcode [NCH];
	logic [NCH-1:0] hit, act;
	logic restart_ff, nxt_restart_ff;

	always_comb
	begin
		for (int i = 0; i < NCH; i++)
		begin
			cand[i] = CODE_OK;
			if (ch_on[i] && (ovl_s[i] || ot_s[i]))
				cand[i] = CODE_OVL;
			else if (!ch_on[i] && byp_s[i])
				cand[i] = CODE_BYPASS;
			else if (!ch_on[i] && open_s[i])
				cand[i] = CODE_OPEN;
		end
	end

	for (genvar g = 0; g < NCH; g++)
	begin : g_filt
		sfd_filter #(.CNT_W(FILT_W)) u_filt (
			.clk      (ref_clk),
			.nrst     (nrst),
			.restart  (restart_ff),
			.code     (cand[g]),
			.limit    (FILT_W'(FILT_CYCLES)),
			.hit      (hit[g]),
			.hit_code (hcode[g]),
			.active   (act[g])
		);
	end

	// first current rise after turn-on of a regulating channel, timed against the off time
	logic [TMR_W-1:0] tmr_ff [NREG];
	logic [TMR_W-1:0] nxt_tmr_ff [NREG];
	logic [NREG-1:0]  armed_ff, nxt_armed_ff, cur_prev_ff, fast;
	logic [NCH-1:0]   on_prev_ff, on_rise;
	logic [TMR_W-1:0] fo_lim;
	logic [NCH-1:0]   fast_ch;

	assign on_rise = ch_on & ~on_prev_ff;
	// zero-extended so the per-channel loop reads no fast rise on channels past the regulated ones
	assign fast_ch = NCH'(fast);

	always_comb
	begin
		fast         = '0;
		nxt_armed_ff = armed_ff;
		fo_lim       = '0;
		for (int i = 0; i < NREG; i++)
		begin
			nxt_tmr_ff[i] = tmr_ff[i];
			fo_lim = TMR_W'(FO_UNIT_CYCLES * (int'(fixed_off_time[2*i +: 2]) + 1));
			if (on_rise[i])
			begin
				nxt_tmr_ff[i]   = '0;
				nxt_armed_ff[i] = 1'b1;
			end
			else
			begin
				if (ch_on[i] && tmr_ff[i] != '1)
					nxt_tmr_ff[i] = tmr_ff[i] + 1'b1;
				if (armed_ff[i] && cur_s[i] && !cur_prev_ff[i])
				begin
					nxt_armed_ff[i] = 1'b0; // only the first rising edge counts
					fast[i] = reg_mode_on[i] && ch_on[i] && tmr_ff[i] < fo_lim;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < NREG; i++)
				tmr_ff[i] <= '0;
			armed_ff    <= '0;
			cur_prev_ff <= '0;
			on_prev_ff  <= '0;
		end
		else
		begin
			for (int i = 0; i < NREG; i++)
				tmr_ff[i] <= nxt_tmr_ff[i];
			armed_ff    <= nxt_armed_ff;
			cur_prev_ff <= cur_s;
			on_prev_ff  <= ch_on;
		end
	end

	// frame tracking, diagnosis store, snapshot and outputs
	logic [2*NCH-1:0] codes_ff, nxt_codes_ff;
	logic [NCH-1:0]   chot_ff, nxt_chot_ff;
	logic [DW-1:0]    snap_ff, nxt_snap_ff, diag, cmd_ff, nxt_cmd_ff;
	logic [CW-1:0]    base_ff, nxt_base_ff;
	logic             cs_prev_ff, strobe_ff, nxt_strobe_ff, oe_ff, nxt_oe_ff;
	logic             fault_n_ff, nxt_fault_n_ff, ch6_diag_or_overtemp_out_ff, nxt_ch6_diag_or_overtemp_out_ff;
	logic             cs_fall, cs_rise, valid;
	logic [3:0]       cmd;

	assign cs_fall = cs_prev_ff && !cs_s;
	assign cs_rise = !cs_prev_ff && cs_s;
	assign cmd     = lnk.rx_word[POS_CMD +: 4];
	// counts and word are quiet here: the serial clock idles at both chip select edges
	assign valid   = cs_rise && CW'(lnk.smp_cnt - base_ff) == FRAME_BITS
		&& cmd[3] && cmd != CMD_UNUSED;
	assign diag    = {codes_ff, |chot_ff, chip_ot_s, FIXED_ONES};

	always_comb
	begin
		nxt_codes_ff   = codes_ff;
		nxt_chot_ff    = chot_ff;
		nxt_snap_ff    = snap_ff;
		nxt_base_ff    = base_ff;
		nxt_cmd_ff     = cmd_ff;
		nxt_strobe_ff  = 1'b0;
		nxt_restart_ff = 1'b0;
		nxt_oe_ff      = !cs_s;
		if (valid)
		begin
			nxt_codes_ff   = '1;
			nxt_restart_ff = 1'b1;
			nxt_strobe_ff  = 1'b1;
			nxt_cmd_ff     = lnk.rx_word;
		end
		// invalid frames fall through: word dropped, codes kept
		for (int i = 0; i < NCH; i++)
		begin
			if (hit[i])
				nxt_codes_ff[2*i +: 2] = hcode[i];
			else if (fast_ch[i])
				nxt_codes_ff[2*i +: 2] = CODE_OVL;
			if (on_rise[i])
				nxt_chot_ff[i] = 1'b0;
			if (ch_on[i] && ot_s[i])
				nxt_chot_ff[i] = 1'b1;
		end
		// snapshot frozen while selected so the link sees a steady word
		if (cs_s)
			nxt_snap_ff = diag;
		if (cs_fall)
			nxt_base_ff = lnk.smp_cnt;
		nxt_fault_n_ff = !(codes_ff != '1);
		if (ot_flag_mode)
			nxt_ch6_diag_or_overtemp_out_ff = !(|chot_ff || chip_ot_s);
		else
			nxt_ch6_diag_or_overtemp_out_ff = ch_on[NCH-1] ^ act[NCH-1];
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			codes_ff   <= '1;
			chot_ff    <= '0;
			snap_ff    <= '1;
			base_ff    <= '0;
			cmd_ff     <= '0;
			strobe_ff  <= 1'b0;
			restart_ff <= 1'b0;
			oe_ff      <= 1'b0;
			cs_prev_ff <= 1'b1;
			fault_n_ff <= 1'b1;
			ch6_diag_or_overtemp_out_ff   <= 1'b1;
		end
		else
		begin
			codes_ff   <= nxt_codes_ff;
			chot_ff    <= nxt_chot_ff;
			snap_ff    <= nxt_snap_ff;
			base_ff    <= nxt_base_ff;
			cmd_ff     <= nxt_cmd_ff;
			strobe_ff  <= nxt_strobe_ff;
			restart_ff <= nxt_restart_ff;
			oe_ff      <= nxt_oe_ff;
			cs_prev_ff <= cs_s;
			fault_n_ff <= nxt_fault_n_ff;
			ch6_diag_or_overtemp_out_ff   <= nxt_ch6_diag_or_overtemp_out_ff;
		end
	end

	assign lnk.snap                 = snap_ff;
	assign lnk.base                 = base_ff;
	assign so_oe                    = oe_ff;
	assign fault_n                  = fault_n_ff;
	assign ch6_diag_or_overtemp_out = ch6_diag_or_overtemp_out_ff;
	assign cmd_word                 = cmd_ff;
	assign cmd_strobe               = strobe_ff;

	// checks on the diagnosis path
	ones_bits_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		snap_ff[1:0] == FIXED_ONES && diag[1:0] == FIXED_ONES)
		else $error("fixed bits not ones");

	oe_release_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		cs_rise |=> !so_oe ##1 !so_oe)
		else $error("serial out driven while deselected");

	snap_freeze_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!cs_s && !cs_prev_ff) |=> $stable(snap_ff))
		else $error("snapshot moved during frame");

	clear_codes_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(valid && hit == '0 && fast == '0) |=> codes_ff == '1 && cmd_strobe ##1 !cmd_strobe)
		else $error("valid frame did not clear diagnosis");

	invalid_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(cs_rise && !valid && hit == '0 && fast == '0) |=> $stable(codes_ff) && !cmd_strobe)
		else $error("invalid frame changed diagnosis");

	chot_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(valid && on_rise == '0) |=> (chot_ff & $past(chot_ff)) == $past(chot_ff))
		else $error("channel overtemp flag lost on frame");

	fault_low_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(hit != '0) |=> ##1 !fault_n)
		else $error("fault output not low after record");

	chip_ot_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(cs_s && cs_prev_ff) |=> snap_ff[POS_CHIP_OT] == $past(chip_ot_s))
		else $error("chip overtemp bit not live");

	ch6_diag_or_overtemp_out_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(ot_flag_mode && chot_ff != '0) |=> !ch6_diag_or_overtemp_out)
		else $error("overtemp flag pin not low");
endmodule

// [core/sfd_pkg.sv]
package sfd_pkg;
	// channel counts
	localparam int NCH  = 6;
	localparam int NREG = 3;

	// clock rate and derived times
	localparam int CLK_MHZ      = 100;
	localparam int FILT_TIME_US = 100;
	localparam int FILT_CYC     = FILT_TIME_US * CLK_MHZ;
	localparam int FO_UNIT_US   = 100;
	localparam int FO_UNIT_CYC  = FO_UNIT_US * CLK_MHZ;
	localparam int FILT_W       = 16;
	localparam int TMR_W        = 16;

	// diagnosis word layout
	localparam int DW          = 16;
	localparam int POS_CH_LSB  = 4;
	localparam int POS_CH_OT   = 3;
	localparam int POS_CHIP_OT = 2;
	localparam logic [1:0] FIXED_ONES = 2'h3;

	// per channel codes
	localparam logic [1:0] CODE_OK     = 2'h3;
	localparam logic [1:0] CODE_OVL    = 2'h2;
	localparam logic [1:0] CODE_OPEN   = 2'h1;
	localparam logic [1:0] CODE_BYPASS = 2'h0;

	// frame framing and command field
	localparam int CW = 5;
	localparam logic [CW-1:0] FRAME_BITS = 5'h10;
	localparam int POS_CMD = 12;
	localparam logic [3:0] CMD_UNUSED = 4'hE;
endpackage

// [core/sfd_if.sv]
interface sfd_if import sfd_pkg::*;;
	// diagnosis snapshot and frame base count, ref_clk side
	logic [DW-1:0] snap;
	logic [CW-1:0] base;
	// sample edge count and received word, link side
	logic [CW-1:0] smp_cnt;
	logic [DW-1:0] rx_word;

	modport core (output snap, output base, input smp_cnt, input rx_word);
	modport link (input snap, input base, output smp_cnt, output rx_word);
endinterface

// [core/sfd_filter.sv]
module sfd_filter import sfd_pkg::*; #(
	parameter int CNT_W = FILT_W
)(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// candidate fault and timing
	input  wire logic             restart,
	input  wire logic [1:0]       code,
	input  wire logic [CNT_W-1:0] limit,
	// filtered result
	output logic                  hit,
	output logic [1:0]            hit_code,
	output logic                  active
);
	logic [1:0]       cand_ff, nxt_cand_ff, hcode_ff, nxt_hcode_ff;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt_ff;
	logic             done_ff, nxt_done_ff, hit_ff, nxt_hit_ff;

	// a changed condition starts a fresh persistence count
	always_comb
	begin
		nxt_cand_ff  = code;
		nxt_cnt_ff   = cnt_ff;
		nxt_done_ff  = done_ff;
		nxt_hit_ff   = 1'b0;
		nxt_hcode_ff = hcode_ff;
		if (restart || code != cand_ff)
		begin
			nxt_cnt_ff  = '0;
			nxt_done_ff = 1'b0;
		end
		else if (cand_ff != CODE_OK && !done_ff)
		begin
			if (cnt_ff == limit)
			begin
				nxt_hit_ff   = 1'b1;
				nxt_done_ff  = 1'b1;
				nxt_hcode_ff = cand_ff;
			end
			else
				nxt_cnt_ff = cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cand_ff  <= CODE_OK;
			cnt_ff   <= '0;
			done_ff  <= 1'b0;
			hit_ff   <= 1'b0;
			hcode_ff <= CODE_OK;
		end
		else
		begin
			cand_ff  <= nxt_cand_ff;
			cnt_ff   <= nxt_cnt_ff;
			done_ff  <= nxt_done_ff;
			hit_ff   <= nxt_hit_ff;
			hcode_ff <= nxt_hcode_ff;
		end
	end

	assign hit      = hit_ff;
	assign hit_code = hcode_ff;
	assign active   = done_ff;

	filt_hit_time_a: assert property (@(posedge clk) disable iff (!nrst)
		hit_ff |-> ($past(cnt_ff) == limit && done_ff && hcode_ff != CODE_OK))
		else $error("fault recorded before filter time");
endmodule

// [core/sfd_spi.sv]
module sfd_spi import sfd_pkg::*; (
	// link pins
	input  wire logic sclk,
	input  wire logic nrst,
	input  wire logic clock_polarity_select,
	input  wire logic si,
	// core side
	sfd_if.link       lnk,
	// serial data out
	output logic      so
);
	logic          spi_clk;
	logic [DW-1:0] rx_ff, nxt_rx_ff;
	logic [CW-1:0] smp_ff, nxt_smp_ff, idx;
	logic          so_ff, nxt_so_ff;

	// polarity select turns the sampling edge into a rising edge; it is a static strap
	assign spi_clk = sclk ^ clock_polarity_select;

	// sampling edge: shift in, count edges; counts are free running so no reset by chip select
	always_comb
	begin
		nxt_rx_ff  = {rx_ff[DW-2:0], si};
		nxt_smp_ff = smp_ff + 1'b1;
	end

	always_ff @(posedge spi_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_ff  <= '0;
			smp_ff <= '0;
		end
		else
		begin
			rx_ff  <= nxt_rx_ff;
			smp_ff <= nxt_smp_ff;
		end
	end

	// opposite edge presents the next bit, msb first
	always_comb
	begin
		idx       = smp_ff - lnk.base;
		nxt_so_ff = (idx < FRAME_BITS) ? lnk.snap[4'hF - idx[3:0]] : 1'b0;
	end

	always_ff @(negedge spi_clk or negedge nrst)
	begin
		if (!nrst)
			so_ff <= 1'b0;
		else
			so_ff <= nxt_so_ff;
	end

	// before the first shift edge of a frame the msb shows straight from the snapshot
	assign so          = (smp_ff == lnk.base) ? lnk.snap[DW-1] : so_ff;
	assign lnk.smp_cnt = smp_ff;
	assign lnk.rx_word = rx_ff;
endmodule

// [sim/sfd_host.sv]
module sfd_host #(
	parameter int GAP_NS = 400
)(
	// core clock, used only to align chip select
	input  wire logic ref_clk,
	// link pins
	input  wire logic pol,
	output logic      cs_n,
	output logic      sclk,
	output logic      si,
	input  wire logic so,
	input  wire logic so_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle link: select off, clock parked high for the default polarity
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b1;
		si   = 1'b0;
	end

	// one frame, msb first both ways; sclk is parked at ~pol before select and toggles only inside the frame
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx, output logic oe_on, output logic oe_off);
		sclk = ~pol;
		#40;
		@(negedge ref_clk);
		cs_n = 1'b0;
		#200;
		oe_on = so_oe;
		for (int i = 15; i >= 0; i--)
		begin
			sclk = pol;
			si   = tx[i];
			#16;
			rx[i] = so;
			sclk  = ~pol;
			#16;
		end
		#200;
		@(negedge ref_clk);
		cs_n = 1'b1;
		// released data line must not look like a held value
		si = ~tx[0];
		#60;
		oe_off = so_oe;
		// gap scaled to the shortened filter time
		#(GAP_NS - 60);
	endtask
endmodule

// [sim/sfd_diag_tb_top.sv]
module sfd_diag_tb_top import sfd_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	// short filter and off-time units keep the run brief
	localparam int FILT = 20;
	localparam int FOU  = 30;

	logic              ref_clk;
	logic              nrst;
	logic              sclk;
	logic              cs_n;
	logic              si;
	logic              pol;
	logic              so;
	logic              so_oe;
	logic [NCH-1:0]    ovl;
	logic [NCH-1:0]    chot;
	logic [NCH-1:0]    opn;
	logic [NCH-1:0]    byp;
	logic [NCH-1:0]    on;
	logic              chip_ot;
	logic [NREG-1:0]   cur;
	logic [NREG-1:0]   regm;
	logic [2*NREG-1:0] fot;
	logic              otm;
	logic              fault_n;
	logic              d6;
	logic [DW-1:0]     cmd_word;
	logic              cmd_strobe;
	logic [15:0]       rx;
	logic              oe1;
	logic              oe0;
	int                error_cnt;
	int                comparisons;
	int                cyc;
	int                strobes;

	sfd_diag #(.FILT_CYCLES(FILT), .FO_UNIT_CYCLES(FOU)) i_sfd_diag (
		.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .si(si),
		.clock_polarity_select(pol), .so(so), .so_oe(so_oe),
		.ovl_det(ovl), .ch_ot_det(chot), .open_load_det(opn), .bypass_det(byp),
		.chip_ot_det(chip_ot), .cur_reached(cur), .ch_on(on), .reg_mode_on(regm),
		.fixed_off_time(fot), .ot_flag_mode(otm), .fault_n(fault_n),
		.ch6_diag_or_overtemp_out(d6), .cmd_word(cmd_word), .cmd_strobe(cmd_strobe)
	);

	sfd_host i_sfd_host (
		.ref_clk(ref_clk), .pol(pol), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe)
	);

	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	// strobe counter and hang guard; strobe is one cycle wide so count per edge
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cmd_strobe === 1'b1)
			strobes++;
		if (cyc == 20000)
		begin
			error_cnt++;
			$display("MISMATCH %0t timeout", $time);
			results();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one frame, then word and output enable checks
	task automatic rd(input logic [15:0] cmd, input logic [15:0] exp, input string what);
		i_sfd_host.xfer(cmd, rx, oe1, oe0);
		chk(rx, exp, what);
		chk({14'h0000, oe1, oe0}, 16'h0002, "so enable");
	endtask

	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		{ovl, chot, opn, byp, on, chip_ot, cur, regm, fot} = '0;
		{pol, error_cnt, comparisons, cyc, strobes} = '0;
		otm  = 1'b1;
		nrst = 1'b0;
		wt(3);
		nrst = 1'b1;
		wt(3);
		chk({15'h0000, fault_n}, 16'h0001, "reset fault_n");
		rd(16'h8000, 16'hFFF3, "idle word");
		chk(cmd_word, 16'h8000, "cmd word");
		$display("test idle done");
		// mixed faults, channel 6 and chip overtemperature in flag mode
		on      = 6'h21;
		ovl     = 6'h01;
		opn     = 6'h02;
		byp     = 6'h04;
		chot    = 6'h20;
		chip_ot = 1'b1;
		wt(60);
		chk({15'h0000, fault_n}, 16'h0000, "fault_n low");
		chk({15'h0000, d6}, 16'h0000, "overtemp pin");
		rd(16'hE000, 16'hBC6F, "fault word");
		chk(strobes[15:0], 16'h0001, "invalid strobe");
		{ovl, opn, byp, chot, chip_ot} = '0;
		wt(40);
		rd(16'h9000, 16'hBC6B, "kept word");
		rd(16'hA000, 16'hFFFB, "cleared word");
		chk({15'h0000, fault_n}, 16'h0001, "fault_n cleared");
		on[5] = 1'b0;
		wt(5);
		on[5] = 1'b1;
		wt(5);
		rd(16'hB000, 16'hFFF3, "flag off");
		$display("test faults done");
		// bypass then open load on channel 4: newer code wins
		byp = 6'h08;
		wt(60);
		byp = 6'h00;
		opn = 6'h08;
		wt(60);
		opn = 6'h00;
		rd(16'hC000, 16'hF7F3, "overwrite");
		$display("test overwrite done");
		// channel 1 reaches current fast, channel 2 late; ch1 is cycled so its turn-on arms the check
		on = 6'h20;
		wt(2);
		regm = 3'h3;
		on   = 6'h23;
		wt(5);
		cur[0] = 1'b1;
		wt(50);
		cur[1] = 1'b1;
		wt(40);
		cur = '0;
		rd(16'hD000, 16'hFFE3, "fast rise");
		$display("test fast rise done");
		// reversed clock polarity
		on   = '0;
		regm = '0;
		wt(10);
		pol = 1'b1;
		wt(10);
		rd(16'hF000, 16'hFFF3, "polarity one");
		chk(cmd_word, 16'hF000, "last cmd");
		chk(strobes[15:0], 16'h0007, "valid strobes");
		$display("test polarity done");
		// channel 6 diagnosis mode: pin follows the switch, inverted while a filtered fault stands
		otm = 1'b0;
		byp = 6'h20;
		wt(40);
		chk({15'h0000, d6}, 16'h0001, "ch6_diag_or_overtemp_out fault");
		byp = '0;
		wt(10);
		chk({15'h0000, d6}, 16'h0000, "ch6_diag_or_overtemp_out clear");
		$display("test diag mode done");
		results();
	end
endmodule
